// [logic/emt_tile.sv]
// memory tile with two ports, byte masks, address hold and apb configuration
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
`include "emt_defines.svh"
module emt_tile #(
  parameter int DEPTH = 256                // words of 36 bits
) (
  input  wire logic            mclk,      // 25 MHz clock
  input  wire logic            rst,       // synchronous reset, high
  input  wire logic            psel,      // apb select
  input  wire logic            penable,   // apb enable
  input  wire logic            pwrite,    // apb direction
  input  wire logic [11:0]     paddr,     // apb byte address
  input  wire logic [31:0]     pwdata,    // apb write data
  output logic      [31:0]     prdata,    // apb read data
  output logic                 pready,    // apb ready
  output logic                 pslverr,   // apb error
  input  emt_pkg::emt_req_t    req_a,     // port a request
  input  emt_pkg::emt_req_t    req_b,     // port b request
  output logic      [35:0]     dout_a,    // port a read data
  output logic      [35:0]     dout_b     // port b read data
);
  import emt_pkg::*;

  localparam int IW = $clog2(DEPTH);

  // lane placement of write data and mask into a stored word
  function automatic emt_lane_t lane_map(emt_width_t w, logic half, logic [35:0] d, logic [3:0] be);
    emt_lane_t r;
    int        k;
    int        h;
    r = '0;
    h = half ? 2 : 0;
    for (k = 0; k < 4; k++) begin
      case (w)
        EMT_W36: begin
          r.data[9*k +: 9] = d[9*k +: 9];
          r.mask[9*k +: 9] = {9{be[k]}};
        end
        EMT_W32: begin
          r.data[9*k +: 8] = d[8*k +: 8];
          r.mask[9*k +: 8] = {8{be[k]}};
        end
        EMT_W18: begin
          if (k < 2) begin
            r.data[9*(k+h) +: 9] = d[9*k +: 9];
            r.mask[9*(k+h) +: 9] = {9{be[k]}};
          end
        end
        default: begin
          if (k < 2) begin
            r.data[9*(k+h) +: 8] = d[8*k +: 8];
            r.mask[9*(k+h) +: 8] = {8{be[k]}};
          end
        end
      endcase
    end
    return r;
  endfunction

  // extraction of read data from a stored word
  function automatic logic [35:0] lane_get(emt_width_t w, logic half, logic [35:0] word);
    logic [35:0] r;
    int          k;
    int          h;
    r = '0;
    h = half ? 2 : 0;
    for (k = 0; k < 4; k++) begin
      case (w)
        EMT_W36: r[9*k +: 9] = word[9*k +: 9];
        EMT_W32: r[8*k +: 8] = word[9*k +: 8];
        EMT_W18: begin
          if (k < 2) begin
            r[9*k +: 9] = word[9*(k+h) +: 9];
          end
        end
        default: begin
          if (k < 2) begin
            r[8*k +: 8] = word[9*(k+h) +: 8];
          end
        end
      endcase
    end
    return r;
  endfunction

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // configuration and apb state
  logic [`EMT_CTRL_W-1:0] ctrl_ff;
  logic [31:0]            prdata_ff;
  logic                   pready_ff;
  logic                   pslverr_ff;

  // storage: 256 words x 36 bits, no reset so contents survive clears
  logic [35:0]            mem_ff [DEPTH];

  // per-port state
  logic [8:0]             addr_ff  [2];
  logic [35:0]            din_ff   [2];
  logic [3:0]             be_ff    [2];
  logic                   wr_ff    [2];
  logic                   rd_ff    [2];
  logic [35:0]            latch_ff [2];
  logic [35:0]            dout_ff  [2];

  // per-port decode
  emt_req_t               req      [2];
  emt_width_t             width    [2];
  logic [IW-1:0]          idx      [2];
  logic                   half     [2];
  logic [3:0]             be_eff   [2];
  logic                   exec_wr  [2];
  logic                   exec_rd  [2];
  emt_lane_t              lane     [2];
  logic [35:0]            merged   [2];

  wire emt_mode_t mode     = emt_mode_t'(ctrl_ff[`EMT_MODE_LSB +: 2]);
  wire            narrowed = (mode == EMT_TRUE) || (mode == EMT_PACKED);

  assign req[0] = req_a;
  assign req[1] = req_b;

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_port
      wire emt_width_t w_raw  = emt_width_t'(ctrl_ff[`EMT_WID_LSB + 2*p +: 2]);
      wire             rdwnew = ctrl_ff[`EMT_RDWNEW_LSB + p];
      wire             rduse  = ctrl_ff[`EMT_RDUSE_LSB + p];
      wire             beuse  = ctrl_ff[`EMT_BEUSE_LSB + p];
      wire             on     = (p == 0) || (mode != EMT_SINGLE);
      wire             wr_ok  = on && !((p == 1) && (mode == EMT_SIMPLE));
      wire             rd_ok  = on && !((p == 0) && (mode == EMT_SIMPLE));
      wire             ce     = req[p].ce_in;
      // address register fed back through a mux while held
      wire [8:0]       nxt_addr = req[p].hold ? addr_ff[p] : req[p].addr;
      wire             wide     = (width[p] == EMT_W36) || (width[p] == EMT_W32);
      wire [IW-1:0]    raw_idx  = wide ? addr_ff[p][IW-1:0] : addr_ff[p][IW:1];
      wire [35:0]      old      = mem_ff[idx[p]];
      wire [35:0]      view     = rdwnew ? merged[p] : old;

      // width clamp to 18 bits in true dual and packed modes
      assign width[p] = !narrowed ? w_raw :
                        (w_raw == EMT_W36) ? EMT_W18 :
                        (w_raw == EMT_W32) ? EMT_W16 : w_raw;
      assign half[p]    = wide ? 1'b0 : addr_ff[p][0];
      // packed mode splits the tile: port a low half, port b high half
      assign idx[p]     = (mode == EMT_PACKED) ? {1'(p), raw_idx[IW-2:0]} : raw_idx;
      assign be_eff[p]  = beuse ? be_ff[p] : 4'hf;
      assign exec_wr[p] = ce && wr_ff[p];
      assign exec_rd[p] = ce && rd_ff[p];
      assign lane[p]    = lane_map(width[p], half[p], din_ff[p], be_eff[p]);
      assign merged[p]  = (old & ~lane[p].mask) | (lane[p].data & lane[p].mask);

      // input registers, captured only with clock enable high
      always_ff @(posedge mclk) begin
        if (rst) begin
          addr_ff[p] <= 9'h000;
          wr_ff[p]   <= 1'b0;
          rd_ff[p]   <= 1'b0;
          din_ff[p]  <= 36'h0;
        end else if (ce) begin
          addr_ff[p] <= nxt_addr;
          wr_ff[p]   <= req[p].wren && wr_ok;
          rd_ff[p]   <= (req[p].rden || !rduse) && rd_ok;
          din_ff[p]  <= req[p].din;
        end
      end

      // byte mask capture, no clear of any kind
      always_ff @(posedge mclk) begin
        if (ce) begin
          be_ff[p] <= req[p].be;
        end
      end

      // output latch: write without read keeps last read data
      always_ff @(posedge mclk) begin
        if (rst || req[p].clr) begin
          latch_ff[p] <= 36'h0;
        end else if (exec_rd[p]) begin
          latch_ff[p] <= lane_get(width[p], half[p], exec_wr[p] ? view : old);
        end
      end

      // output register on the second clock enable
      always_ff @(posedge mclk) begin
        if (rst || req[p].clr) begin
          dout_ff[p] <= 36'h0;
        end else if (req[p].ce_out) begin
          dout_ff[p] <= latch_ff[p];
        end
      end

      hold_addr_a: assert property (ce && req[p].hold |=> $stable(addr_ff[p]))
        else $error("address register moved while held");
      ce_stall_a: assert property (!ce && !req[p].clr |=>
                                   $stable(addr_ff[p]) && $stable(latch_ff[p]) && $stable(wr_ff[p]))
        else $error("port state moved with clock enable low");
      rd_keep_a: assert property (exec_wr[p] && !exec_rd[p] && !req[p].clr |=> $stable(latch_ff[p]))
        else $error("output changed on write without read");
      mask_noclr_a: assert property (disable iff (1'b0) (rst || req[p].clr) && !ce |=> $stable(be_ff[p]))
        else $error("byte mask register cleared");
      out_reg_a: assert property (req[p].ce_out && !req[p].clr |=> dout_ff[p] == $past(latch_ff[p]))
        else $error("output register did not follow latch");
      out_clr_a: assert property (req[p].clr |=> dout_ff[p] == 36'h0 ##1 latch_ff[p] == $past(latch_ff[p]) || exec_rd[p])
        else $error("clear did not zero the output");
      packed_half_a: assert property (mode == EMT_PACKED |-> idx[p][IW-1] == 1'(p) && width[p] != EMT_W36)
        else $error("packed port left its half");
      rdw_new_a: assert property (exec_wr[p] && exec_rd[p] && rdwnew && be_eff[p] == 4'hf && width[p] == EMT_W36
                                  && !req[p].clr |=> latch_ff[p] == $past(din_ff[p]))
        else $error("new data not shown on read during write");
    end
  endgenerate

  // second port merges onto the first when both write one word
  wire [35:0] base_b   = (exec_wr[0] && idx[0] == idx[1]) ? merged[0] : mem_ff[idx[1]];
  wire [35:0] merged_b = (base_b & ~lane[1].mask) | (lane[1].data & lane[1].mask);

  // array write, port b last so a shared word keeps both ports' lanes
  always_ff @(posedge mclk) begin
    if (exec_wr[0]) begin
      mem_ff[idx[0]] <= merged[0];
    end
    if (exec_wr[1]) begin
      mem_ff[idx[1]] <= merged_b;
    end
  end

  mask_hold_a: assert property (exec_wr[0] && !exec_wr[1] |=>
                                (mem_ff[$past(idx[0])] & ~$past(lane[0].mask)) ==
                                ($past(mem_ff[idx[0]]) & ~$past(lane[0].mask)))
    else $error("masked byte was overwritten");

  // apb decode
  wire        apb_acc  = psel && penable;
  wire        sel_ctrl = paddr == `EMT_CTRL_OFS;
  wire        sel_stat = paddr == `EMT_STAT_OFS;
  wire        apb_bad  = !(sel_ctrl || sel_stat) || (pwrite && sel_stat);
  wire [31:0] stat_val = {7'h00, addr_ff[1], 7'h00, addr_ff[0]};
  wire [31:0] rd_val   = sel_ctrl ? {{(32-`EMT_CTRL_W){1'b0}}, ctrl_ff} : sel_stat ? stat_val : 32'h0;

  // apb slave: one wait state, write commits at the ready edge
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_ff    <= `EMT_CTRL_RST;
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= apb_acc && !pready_ff;
      if (apb_acc && !pready_ff) begin
        prdata_ff  <= pwrite ? 32'h0 : rd_val;
        pslverr_ff <= apb_bad;
      end
      if (apb_acc && pready_ff && pwrite && sel_ctrl) begin
        ctrl_ff <= pwdata[`EMT_CTRL_W-1:0];
      end
    end
  end

  apb_ready_a: assert property (apb_acc && !pready_ff |=> pready_ff ##1 !pready_ff)
    else $error("apb ready not one wait state");

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign dout_a  = dout_ff[0];
  assign dout_b  = dout_ff[1];

endmodule

// [logic/emt_defines.svh]
// offsets, field positions and reset values of the memory tile
//
// Behaviour
// - tile stores 8,192 data bits plus one extra bit per byte, 9,216 total
// - each port has its own read strobe and write strobe, each suppressible alone
// - clock enable low: no input, mask or latch register on that port moves except on clear, no operation happens
// - ports A and B each have two separate clock enable inputs
// - extra byte bit stored and returned like data; no parity computed or checked
// - write with read strobe present but low keeps the last read output
// - read strobe high or unused during same-address write gives new or old data
// - bytes whose mask bit is low are not written and keep old contents
// - unused byte mask defaults to all ones; writes need strobe and mask bit
// - byte mask capture registers have no clear and ignore every clear
// - byte masking exists only for 16, 18, 32 and 36 bit write widths
// - mask bit 0 is lowest lane; lanes 8 bits wide, or 9 in 18/36 modes
// - mask bits active high; any combination of lanes accepted
// - during a write, output byte of a masked-off lane shows old stored data
// - during a write, output byte of an enabled lane shows new or old by setting
// - packed mode: two single-port half-size memories, at most 18 bits, one clock
// - while address hold is 1 the address register keeps its previous value
// - each port has its own address hold acting only on its own address
// - address hold is a mux feeding the address register back, default low
// - single and simple dual modes take every width; true dual allows any two ops
// - clear acts on output registers only; memory contents are never cleared
`ifndef EMT_DEFINES_SVH
`define EMT_DEFINES_SVH
`define EMT_CTRL_OFS   12'h000
`define EMT_STAT_OFS   12'h004
`define EMT_MODE_LSB   0
`define EMT_WID_LSB    2
`define EMT_RDWNEW_LSB 6
`define EMT_RDUSE_LSB  8
`define EMT_BEUSE_LSB  10
`define EMT_CTRL_W     12
`define EMT_CTRL_RST   12'hf00
`define EMT_STAT_BLSB  16
`endif

// [logic/emt_pkg.sv]
// types shared by the memory tile
package emt_pkg;
  typedef enum logic [1:0] {
    EMT_W36 = 2'h0,
    EMT_W32 = 2'h1,
    EMT_W18 = 2'h2,
    EMT_W16 = 2'h3
  } emt_width_t;
  typedef enum logic [1:0] {
    EMT_SINGLE = 2'h0,
    EMT_SIMPLE = 2'h1,
    EMT_TRUE   = 2'h2,
    EMT_PACKED = 2'h3
  } emt_mode_t;
  typedef struct packed {
    logic [8:0]  addr;
    logic [35:0] din;
    logic [3:0]  be;
    logic        wren;
    logic        rden;
    logic        hold;
    logic        ce_in;
    logic        ce_out;
    logic        clr;
  } emt_req_t;
  typedef struct packed {
    logic [35:0] data;
    logic [35:0] mask;
  } emt_lane_t;
endpackage

// [dv/emt_user_port.sv]
// user logic model that drives one port of the memory tile
`timescale 1ns/1ps
module emt_user_port (
  input  wire logic        mclk,  // port clock
  output emt_pkg::emt_req_t req    // request into the tile
);
  import emt_pkg::*;
  // quiet request at time zero
  initial begin
    req = '0;
    req.be = 4'hf;
    req.ce_in = 1'h1;
    req.ce_out = 1'h1;
  end
  // one request for one cycle after the edge; flags f = {wren, rden, hold, ce_in, clr}
  task automatic issue(input logic [8:0] a, input logic [35:0] d, input logic [3:0] b, input logic [4:0] f);
    @(posedge mclk);
    req <= '{addr: a, din: d, be: b, wren: f[4], rden: f[3], hold: f[2],
             ce_in: f[1], ce_out: 1'h1, clr: f[0]};
    @(posedge mclk);
    // idle keeps the address but inverts the data so stale bits never look valid
    req <= '{addr: a, din: ~d, be: b, wren: 1'h0, rden: 1'h0, hold: 1'h0,
             ce_in: 1'h1, ce_out: 1'h1, clr: 1'h0};
  endtask
endmodule

// [dv/emt_tile_tb_top.sv]
// self-checking bench for the memory tile
`timescale 1ns/1ps
`include "emt_defines.svh"
module emt_tile_tb_top;
  import emt_pkg::*;
  localparam logic [4:0] WR = 5'h12;
  localparam logic [4:0] RD = 5'h0a;
  localparam logic [4:0] RDW = 5'h1a;
  localparam logic [4:0] RDH = 5'h0e;
  localparam logic [4:0] NOP = 5'h02;
  localparam logic [4:0] WRNC = 5'h10;
  localparam logic [4:0] CLR = 5'h03;
  localparam logic [4:0] CLRNC = 5'h01;
  localparam logic [4:0] WRH = 5'h16;
  localparam logic [35:0] V3 = 36'h9a5c31e7f;
  localparam logic [35:0] V4 = 36'hff803fe00;
  logic        mclk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [35:0] dout_a;
  logic [35:0] dout_b;
  emt_req_t    req_a;
  emt_req_t    req_b;
  int          err_count;
  int          total_checks;
  emt_tile emt_tile_inst (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .req_a(req_a), .req_b(req_b),
    .dout_a(dout_a), .dout_b(dout_b));
  emt_user_port drv_a (.mclk(mclk), .req(req_a));
  emt_user_port drv_b (.mclk(mclk), .req(req_b));
  // clock
  always #20 mclk = ~mclk;
  // verdict and end of run
  task automatic report_and_stop();
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // compare port data
  task automatic chk36(input logic [35:0] got, input logic [35:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // compare bus data
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      err_count++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // one port request, then the captured op runs and lands in the output register
  task automatic op(input logic b, input logic [8:0] a, input logic [35:0] d, input logic [3:0] be, input logic [4:0] f);
    if (b) drv_b.issue(a, d, be, f);
    else drv_a.issue(a, d, be, f);
    repeat (2) @(posedge mclk);
    #1;
  endtask
  // reset values, read-only and unmapped places
  task automatic t_regs();
    apb(1'h0, `EMT_CTRL_OFS, 32'h0);
    chk32({rd[30:0], err}, {19'h0, `EMT_CTRL_RST, 1'h0});
    apb(1'h1, `EMT_STAT_OFS, 32'hffffffff);
    chk32({31'h0, err}, 32'h1);
    apb(1'h0, 12'h0f0, 32'h0);
    chk32({rd[30:0], err}, 32'h1);
  endtask
  // all 36 bits stored, top address bit ignored at full width
  task automatic t_store();
    op(1'h0, 9'h0ff, V3, 4'hf, WR);
    op(1'h0, 9'h1ff, 36'h0, 4'hf, RD);
    chk36(dout_a, V3);
    op(1'h0, 9'h003, V3, 4'hf, WR);
  endtask
  // lane masking, then masking switched off
  task automatic t_mask();
    op(1'h0, 9'h004, 36'hfffffffff, 4'hf, WR);
    op(1'h0, 9'h004, 36'h0, 4'h5, WR);
    op(1'h0, 9'h004, 36'h0, 4'hf, RD);
    chk36(dout_a, V4);
    apb(1'h1, `EMT_CTRL_OFS, 32'h00000b00);
    op(1'h0, 9'h00a, 36'h123456789, 4'h0, WR);
    op(1'h0, 9'h00a, 36'h0, 4'h0, RD);
    chk36(dout_a, 36'h123456789);
    apb(1'h1, `EMT_CTRL_OFS, 32'h00000f00);
  endtask
  // write with read strobe low keeps last read, clock enable low blocks a write
  task automatic t_rden_ce();
    op(1'h0, 9'h004, 36'h0, 4'hf, RD);
    op(1'h0, 9'h005, 36'h0, 4'hf, WR);
    chk36(dout_a, V4);
    op(1'h0, 9'h004, 36'h0, 4'hf, WRNC);
    op(1'h0, 9'h004, 36'h0, 4'hf, RD);
    chk36(dout_a, V4);
  endtask
  // read during write on own port, old then new data setting
  task automatic t_rdw();
    op(1'h0, 9'h006, 36'h0, 4'hf, WR);
    op(1'h0, 9'h006, 36'hfffffffff, 4'h3, RDW);
    chk36(dout_a, 36'h0);
    op(1'h0, 9'h006, 36'h0, 4'hf, RD);
    chk36(dout_a, 36'h00003ffff);
    apb(1'h1, `EMT_CTRL_OFS, 32'h00000f40);
    op(1'h0, 9'h006, 36'h555555555, 4'h3, RDW);
    chk36(dout_a, 36'h000015555);
    op(1'h0, 9'h006, V3, 4'hf, RDW);
    chk36(dout_a, V3);
    apb(1'h1, `EMT_CTRL_OFS, 32'h00000f00);
  endtask
  // address hold reuses the last captured address
  task automatic t_hold();
    op(1'h0, 9'h003, 36'h0, 4'hf, RD);
    chk36(dout_a, V3);
    op(1'h0, 9'h004, 36'h0, 4'hf, NOP);
    op(1'h0, 9'h003, 36'h0, 4'hf, RDH);
    chk36(dout_a, V4);
  endtask
  // simple dual port, independent holds, clear of the output only
  task automatic t_dual();
    apb(1'h1, `EMT_CTRL_OFS, 32'h00000f01);
    op(1'h0, 9'h008, 36'h0aaaaaaaa, 4'hf, WR);
    op(1'h1, 9'h008, 36'h0, 4'hf, RD);
    chk36(dout_b, 36'h0aaaaaaaa);
    fork
      drv_a.issue(9'h009, 36'h0bbbbbbbb, 4'hf, WRH);
      drv_b.issue(9'h003, 36'h0, 4'hf, RD);
    join
    repeat (2) @(posedge mclk);
    #1;
    chk36(dout_b, V3);
    op(1'h1, 9'h008, 36'h0, 4'hf, RD);
    chk36(dout_b, 36'h0bbbbbbbb);
    op(1'h1, 9'h008, 36'h0, 4'hf, CLR);
    chk36(dout_b, 36'h0);
    op(1'h1, 9'h008, 36'h0, 4'hf, RD);
    chk36(dout_b, 36'h0bbbbbbbb);
    op(1'h1, 9'h008, 36'h0, 4'h0, CLRNC);
    chk36(dout_b, 36'h0);
  endtask
  // packed mode: both ports use one address and stay apart, then captured addresses
  task automatic t_packed();
    apb(1'h1, `EMT_CTRL_OFS, 32'h00000f07);
    fork
      drv_a.issue(9'h007, 36'h00000abcd, 4'h3, WR);
      drv_b.issue(9'h007, 36'h00002a5c3, 4'h3, WR);
    join
    repeat (2) @(posedge mclk);
    #1;
    op(1'h0, 9'h007, 36'h0, 4'hf, RD);
    chk36(dout_a, 36'h00000abcd);
    op(1'h1, 9'h007, 36'h0, 4'hf, RD);
    chk36(dout_b, 36'h00002a5c3);
    apb(1'h0, `EMT_STAT_OFS, 32'h0);
    chk32(rd, 32'h00070007);
  endtask
  // main sequence
  initial begin
    mclk = 1'h0;
    rst = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    err_count = 0;
    total_checks = 0;
    repeat (2) @(posedge mclk);
    rst <= 1'h0;
    t_regs();
    t_store();
    t_mask();
    t_rden_ce();
    t_rdw();
    t_hold();
    t_dual();
    t_packed();
    report_and_stop();
  end
endmodule
